// ---- design/pflag_logic.sv ----
// programmable almost-empty/almost-full flag logic with apb register access
//
// Operation
// - shallow parts: master reset loads n and m from the eight-entry default table
// - deep parts: master reset loads n and m from the deep default table
// - load-select sampled in master reset: high serial, low parallel loading
// - offset registers can be overwritten through the enabled loading method
// - offsets read back on the parallel (apb) port in both modes
// - offsets writable any time after master reset, range 0 to depth-1
// - sync timing: almost-full only on write edges, almost-empty on read edges
// - async timing: almost-full falls on write edge, rises on read edge
// - async timing: almost-empty falls on read edge, rises on write edge
// - empty low at zero, almost-empty low to n, half-full low above half
// - almost-full low at depth-m or more, full low at depth
// - serial load: one bit per write edge, empty lsb first, full msb last
// - when full, further writes are ignored until a read
`timescale 1ns/1ps
module pflag_logic
    import pflag_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF,
    parameter int OW    = $clog2(DEPTH),
    parameter int CW    = OW + 1
) (
    // clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic                   pready_o,
    output logic      [31:0]       prdata_o,
    output logic                   pslverr_o,
    // fifo control pins (asynchronous)
    input  wire logic              master_reset_n_i,
    input  wire logic              load_select_n_i,
    input  wire logic              default_pick_0_i,
    input  wire logic              default_pick_1_i,
    input  wire logic              flag_timing_sel_i,
    input  wire logic              wclk_i,
    input  wire logic              rclk_i,
    input  wire logic              wen_n_i,
    input  wire logic              ren_n_i,
    input  wire logic              serial_load_en_n_i,
    input  wire logic              serial_in_i,
    // status flags, active low
    output logic                   empty_n_o,
    output logic                   almost_empty_n_o,
    output logic                   half_full_n_o,
    output logic                   almost_full_n_o,
    output logic                   full_n_o,
    // interrupt
    output logic                   irq_o
);
    localparam int             TOT      = 2 * OW;
    localparam logic [CW-1:0]  DEPTH_C  = CW'(DEPTH);
    localparam logic [CW-1:0]  HALF_C   = CW'(DEPTH / 2 + 1);
    localparam logic [CW-1:0]  ZERO_C   = '0;
    localparam logic [CW-1:0]  ONE_C    = CW'(1);
    localparam logic           DEEP     = (DEPTH >= DEEP_MIN);
    localparam logic [5:0]     LAST_BIT = 6'(TOT - 1);
    localparam logic [5:0]     BIT_ONE  = 6'h01;
    localparam logic [15:0]    DFLT_RST = DFLT_127;

    // checks all run on clk_i and are off during reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // synchronised pins
    logic [PIN_W-1:0] pins_s;

    pin_sync #(
        .WIDTH   (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({serial_in_i, serial_load_en_n_i, ren_n_i, wen_n_i, rclk_i, wclk_i,
                 flag_timing_sel_i, default_pick_1_i, default_pick_0_i, load_select_n_i,
                 master_reset_n_i}),
        .q_o   (pins_s)
    );

    // state
    logic             wclk_prev_q, wclk_prev_d;
    logic             rclk_prev_q, rclk_prev_d;
    logic             cfg_ld_q, cfg_ld_d;
    logic             cfg_p1_q, cfg_p1_d;
    logic             cfg_p0_q, cfg_p0_d;
    logic             cfg_sync_q, cfg_sync_d;
    logic             mrs_q, mrs_d;
    logic [OW-1:0]    n_q, n_d;
    logic [OW-1:0]    m_q, m_d;
    logic [TOT-1:0]   sh_q, sh_d;
    logic [5:0]       bitcnt_q, bitcnt_d;
    logic [CW-1:0]    count_q, count_d;
    logic             empty_n_q, empty_n_d;
    logic             ae_n_q, ae_n_d;
    logic             hf_n_q, hf_n_d;
    logic             af_n_q, af_n_d;
    logic             full_n_q, full_n_d;
    logic [IRQ_W-1:0] irq_st_q, irq_st_d;
    logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic             irq_q, irq_d;
    logic             pready_q, pready_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pslverr_q, pslverr_d;

    // decoded events
    logic             in_mrs, w_edge, r_edge, ld_pin;
    logic             wr_ev, rd_ev, wr_ok, rd_ok, ser_shift;
    logic             apb_setup, apb_wr, par_ok;
    logic [15:0]      dflt_v;
    logic [IRQ_W-1:0] irq_ev;

    // edges of the sampled write and read clocks
    always_comb begin
        in_mrs      = ~pins_s[PIN_MRS];
        ld_pin      = pins_s[PIN_LD];
        w_edge      = pins_s[PIN_WCLK] & ~wclk_prev_q;
        r_edge      = pins_s[PIN_RCLK] & ~rclk_prev_q;
        wclk_prev_d = pins_s[PIN_WCLK];
        rclk_prev_d = pins_s[PIN_RCLK];
        // memory access needs load-select high
        wr_ev     = w_edge & ~in_mrs & ld_pin & ~pins_s[PIN_WEN];
        rd_ev     = r_edge & ~in_mrs & ld_pin & ~pins_s[PIN_REN];
        wr_ok     = wr_ev & (count_q != DEPTH_C);
        rd_ok     = rd_ev & (count_q != ZERO_C);
        ser_shift = w_edge & ~in_mrs & cfg_ld_q & ~ld_pin
                  & ~pins_s[PIN_SEN];
        apb_setup = psel_i & ~penable_i;
        apb_wr    = psel_i & penable_i & pready_q & pwrite_i;
        par_ok    = ~cfg_ld_q & ~in_mrs;
    end

    // configuration: tracks pins during master reset, frozen afterwards
    always_comb begin
        cfg_ld_d   = cfg_ld_q;
        cfg_p1_d   = cfg_p1_q;
        cfg_p0_d   = cfg_p0_q;
        cfg_sync_d = cfg_sync_q;
        mrs_d      = in_mrs;
        if (in_mrs) begin
            cfg_ld_d   = pins_s[PIN_LD];
            cfg_p1_d   = pins_s[PIN_P1];
            cfg_p0_d   = pins_s[PIN_P0];
            cfg_sync_d = pins_s[PIN_PFM];
        end
        dflt_v = dflt_offset(DEEP, pins_s[PIN_LD], pins_s[PIN_P1], pins_s[PIN_P0]);
    end

    property p_cfg_hold;
        ce_i && !in_mrs |=> $stable(cfg_ld_q) && $stable(cfg_sync_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");

    // offsets: reset default, serial shift or parallel apb write
    always_comb begin
        n_d      = n_q;
        m_d      = m_q;
        sh_d     = sh_q;
        bitcnt_d = bitcnt_q;
        if (in_mrs) begin
            n_d      = dflt_v[OW-1:0];
            m_d      = dflt_v[OW-1:0];
            bitcnt_d = '0;
        end else if (ser_shift) begin
            // partial sets never reach the flags: commit on the last bit only
            sh_d = {pins_s[PIN_SI], sh_q[TOT-1:1]};
            if (bitcnt_q == LAST_BIT) begin
                n_d      = sh_d[OW-1:0];
                m_d      = sh_d[TOT-1:OW];
                bitcnt_d = '0;
            end else begin
                bitcnt_d = bitcnt_q + BIT_ONE;
            end
        end else if (apb_wr && par_ok) begin
            // only OW bits are kept, so 0..depth-1 is all software can reach
            if (paddr_i == OFS_EMPTY) begin
                n_d = pwdata_i[OW-1:0];
            end
            if (paddr_i == OFS_FULL) begin
                m_d = pwdata_i[OW-1:0];
            end
        end
    end

    property p_dflt;
        ce_i && in_mrs |=> n_q == $past(dflt_v[OW-1:0]) && m_q == n_q;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default offset not loaded");

    property p_par_wr;
        ce_i && apb_wr && par_ok && !ser_shift && paddr_i == OFS_EMPTY
            |=> n_q == $past(pwdata_i[OW-1:0]);
    endproperty
    a_par_wr: assert property (p_par_wr) else $error("parallel offset write lost");

    property p_ser_cnt;
        ce_i && ser_shift && bitcnt_q != LAST_BIT |=> bitcnt_q == $past(bitcnt_q) + BIT_ONE;
    endproperty
    a_ser_cnt: assert property (p_ser_cnt) else $error("serial bit not counted");

    // word count
    always_comb begin
        count_d = count_q;
        if (in_mrs) begin
            count_d = '0;
        end else if (wr_ok && !rd_ok) begin
            count_d = count_q + ONE_C;
        end else if (rd_ok && !wr_ok) begin
            count_d = count_q - ONE_C;
        end
    end

    property p_full_hold;
        ce_i && !in_mrs && count_q == DEPTH_C && !rd_ok |=> count_q == DEPTH_C;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("write taken while full");

    // flags from the next count and offsets
    always_comb begin
        empty_n_d = (count_d != ZERO_C);
        full_n_d  = (count_d != DEPTH_C);
        hf_n_d    = (count_d < HALF_C);
        ae_n_d    = ae_n_q;
        af_n_d    = af_n_q;
        if (in_mrs) begin
            ae_n_d = 1'b0;
            af_n_d = 1'b1;
        end else if (cfg_sync_q) begin
            if (w_edge) begin
                af_n_d = (count_d < DEPTH_C - {1'b0, m_d});
            end
            if (r_edge) begin
                ae_n_d = (count_d > {1'b0, n_d});
            end
        end else begin
            if (w_edge && count_d >= DEPTH_C - {1'b0, m_d}) begin
                af_n_d = 1'b0;
            end else if (r_edge && count_d < DEPTH_C - {1'b0, m_d}) begin
                af_n_d = 1'b1;
            end
            if (r_edge && count_d <= {1'b0, n_d}) begin
                ae_n_d = 1'b0;
            end else if (w_edge && count_d > {1'b0, n_d}) begin
                ae_n_d = 1'b1;
            end
        end
    end

    property p_sync_af;
        ce_i && cfg_sync_q && !in_mrs && !w_edge |=> $stable(almost_full_n_o);
    endproperty
    a_sync_af: assert property (p_sync_af) else $error("sync almost-full moved");

    property p_async_af;
        ce_i && !cfg_sync_q && !in_mrs && !almost_full_n_o && !r_edge
            |=> !almost_full_n_o;
    endproperty
    a_async_af: assert property (p_async_af) else $error("almost-full rose early");

    property p_async_ae;
        ce_i && !cfg_sync_q && !in_mrs && !almost_empty_n_o && !w_edge
            |=> !almost_empty_n_o;
    endproperty
    a_async_ae: assert property (p_async_ae) else $error("almost-empty rose early");

    property p_level;
        empty_n_o == (count_q != ZERO_C) && half_full_n_o == (count_q < HALF_C)
            && full_n_o == (count_q != DEPTH_C);
    endproperty
    a_level: assert property (p_level) else $error("level flag wrong");

    // apb slave: one wait-free access, data prepared in the setup cycle
    always_comb begin
        pready_d  = apb_setup;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (apb_setup) begin
            prdata_d = '0;
            case (paddr_i)
                OFS_EMPTY: begin
                    prdata_d[OW-1:0] = n_q;
                    pslverr_d = pwrite_i & ~par_ok;
                end
                OFS_FULL: begin
                    prdata_d[OW-1:0] = m_q;
                    pslverr_d = pwrite_i & ~par_ok;
                end
                OFS_STATUS: begin
                    prdata_d[ST_EMPTY]           = empty_n_q;
                    prdata_d[ST_AE]              = ae_n_q;
                    prdata_d[ST_HF]              = hf_n_q;
                    prdata_d[ST_AF]              = af_n_q;
                    prdata_d[ST_FULL]            = full_n_q;
                    prdata_d[ST_SERIAL]          = cfg_ld_q;
                    prdata_d[ST_SYNC]            = cfg_sync_q;
                    prdata_d[ST_MRS]             = mrs_q;
                    prdata_d[ST_CNT_LSB +: CW]   = count_q;
                end
                OFS_IRQ_STAT: prdata_d[IRQ_W-1:0] = irq_st_q;
                OFS_IRQ_MASK: prdata_d[IRQ_W-1:0] = irq_mask_q;
                default:      pslverr_d = 1'b1;
            endcase
        end
    end

    property p_readback;
        ce_i && apb_setup && paddr_i == OFS_FULL
            |=> prdata_o == 32'($past(m_q)) && pready_o;
    endproperty
    a_readback: assert property (p_readback) else $error("offset readback wrong");

    // interrupt: sticky events, write one to clear, set wins over clear
    always_comb begin
        irq_ev            = '0;
        irq_ev[IRQ_FULL]  = full_n_q & ~full_n_d;
        irq_ev[IRQ_EMPTY] = empty_n_q & ~empty_n_d;
        irq_ev[IRQ_AF]    = af_n_q & ~af_n_d;
        irq_ev[IRQ_AE]    = ae_n_q & ~ae_n_d;
        irq_ev[IRQ_DROP]  = (wr_ev & ~wr_ok) | (rd_ev & ~rd_ok);
        irq_st_d          = irq_st_q;
        irq_mask_d        = irq_mask_q;
        if (apb_wr && paddr_i == OFS_IRQ_STAT) begin
            irq_st_d = irq_st_q & ~pwdata_i[IRQ_W-1:0];
        end
        if (apb_wr && paddr_i == OFS_IRQ_MASK) begin
            irq_mask_d = pwdata_i[IRQ_W-1:0];
        end
        irq_st_d = irq_st_d | irq_ev;
        irq_d    = |(irq_st_d & irq_mask_d);
    end

    // all state registers; clock enable low freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
            cfg_ld_q    <= 1'b0;
            cfg_p1_q    <= 1'b0;
            cfg_p0_q    <= 1'b0;
            cfg_sync_q  <= 1'b0;
            mrs_q       <= 1'b0;
            n_q         <= DFLT_RST[OW-1:0];
            m_q         <= DFLT_RST[OW-1:0];
            sh_q        <= '0;
            bitcnt_q    <= '0;
            count_q     <= '0;
            empty_n_q   <= 1'b0;
            ae_n_q      <= 1'b0;
            hf_n_q      <= 1'b1;
            af_n_q      <= 1'b1;
            full_n_q    <= 1'b1;
            irq_st_q    <= '0;
            irq_mask_q  <= '0;
            irq_q       <= 1'b0;
            pready_q    <= 1'b0;
            prdata_q    <= '0;
            pslverr_q   <= 1'b0;
        end else if (ce_i) begin
            wclk_prev_q <= wclk_prev_d;
            rclk_prev_q <= rclk_prev_d;
            cfg_ld_q    <= cfg_ld_d;
            cfg_p1_q    <= cfg_p1_d;
            cfg_p0_q    <= cfg_p0_d;
            cfg_sync_q  <= cfg_sync_d;
            mrs_q       <= mrs_d;
            n_q         <= n_d;
            m_q         <= m_d;
            sh_q        <= sh_d;
            bitcnt_q    <= bitcnt_d;
            count_q     <= count_d;
            empty_n_q   <= empty_n_d;
            ae_n_q      <= ae_n_d;
            hf_n_q      <= hf_n_d;
            af_n_q      <= af_n_d;
            full_n_q    <= full_n_d;
            irq_st_q    <= irq_st_d;
            irq_mask_q  <= irq_mask_d;
            irq_q       <= irq_d;
            pready_q    <= pready_d;
            prdata_q    <= prdata_d;
            pslverr_q   <= pslverr_d;
        end
    end

    // outputs straight from flops
    assign pready_o         = pready_q;
    assign prdata_o         = prdata_q;
    assign pslverr_o        = pslverr_q;
    assign empty_n_o        = empty_n_q;
    assign almost_empty_n_o = ae_n_q;
    assign half_full_n_o    = hf_n_q;
    assign almost_full_n_o  = af_n_q;
    assign full_n_o         = full_n_q;
    assign irq_o            = irq_q;

endmodule : pflag_logic

// ---- design/pflag_pkg.sv ----
// constants, register map and default-offset decode for the programmable flag logic
package pflag_pkg;

    // depth and depth class
    localparam int DEPTH_DEF = 1024;
    localparam int DEEP_MIN  = 4096;  // first variant with the wider default table

    // apb register map (byte addresses)
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] OFS_EMPTY    = 12'h000;
    localparam logic [11:0] OFS_FULL     = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

    // status register fields
    localparam int ST_EMPTY   = 0;
    localparam int ST_AE      = 1;
    localparam int ST_HF      = 2;
    localparam int ST_AF      = 3;
    localparam int ST_FULL    = 4;
    localparam int ST_SERIAL  = 5;
    localparam int ST_SYNC    = 6;
    localparam int ST_MRS     = 7;
    localparam int ST_CNT_LSB = 16;

    // interrupt status / mask fields
    localparam int IRQ_W     = 5;
    localparam int IRQ_FULL  = 0;
    localparam int IRQ_EMPTY = 1;
    localparam int IRQ_AF    = 2;
    localparam int IRQ_AE    = 3;
    localparam int IRQ_DROP  = 4;

    // synchronised pin vector positions
    localparam int PIN_W    = 11;
    localparam int PIN_MRS  = 0;
    localparam int PIN_LD   = 1;
    localparam int PIN_P0   = 2;
    localparam int PIN_P1   = 3;
    localparam int PIN_PFM  = 4;
    localparam int PIN_WCLK = 5;
    localparam int PIN_RCLK = 6;
    localparam int PIN_WEN  = 7;
    localparam int PIN_REN  = 8;
    localparam int PIN_SEN  = 9;
    localparam int PIN_SI   = 10;
    // active-low pins idle high, the rest low
    localparam logic [PIN_W-1:0] PIN_RST = 11'h383;

    // default offsets
    localparam logic [15:0] DFLT_1023 = 16'h03FF;
    localparam logic [15:0] DFLT_511  = 16'h01FF;
    localparam logic [15:0] DFLT_255  = 16'h00FF;
    localparam logic [15:0] DFLT_127  = 16'h007F;
    localparam logic [15:0] DFLT_63   = 16'h003F;
    localparam logic [15:0] DFLT_31   = 16'h001F;
    localparam logic [15:0] DFLT_15   = 16'h000F;
    localparam logic [15:0] DFLT_7    = 16'h0007;
    localparam logic [15:0] DFLT_3    = 16'h0003;

    // default offset from load-select / pick1 / pick0 pin levels
    function automatic logic [15:0] dflt_offset(input logic deep, input logic ld,
                                                input logic p1, input logic p0);
        logic [15:0] v;
        case ({ld, p1, p0})
            3'b010:  v = DFLT_511;
            3'b001:  v = DFLT_255;
            3'b000:  v = DFLT_127;
            3'b011:  v = DFLT_63;
            3'b100:  v = deep ? DFLT_1023 : DFLT_31;
            3'b110:  v = deep ? DFLT_31 : DFLT_15;
            3'b101:  v = deep ? DFLT_15 : DFLT_7;
            default: v = deep ? DFLT_7 : DFLT_3;
        endcase
        return v;
    endfunction : dflt_offset

endpackage : pflag_pkg

// ---- design/pin_sync.sv ----
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = ce_i ? d_i : meta_q;
        sync_d = ce_i ? meta_q : sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule : pin_sync

// ---- verif/pflag_logic_tb.sv ----
// self-checking bench for the programmable flag logic
`timescale 1ns/1ps
module pflag_logic_tb
    import pflag_pkg::*;
;
    // row: {load, pick1, pick0, timing} beside the default offset it loads
    typedef struct packed {logic [3:0] cfg; logic [9:0] dflt;} row_t;
    localparam row_t ROWS [8] = '{'{4'h9, 10'h01F}, '{4'hC, 10'h00F}, '{4'hB, 10'h007},
        '{4'hE, 10'h003}, '{4'h5, 10'h1FF}, '{4'h2, 10'h0FF}, '{4'h7, 10'h03F},
        '{4'h0, 10'h07F}};
    localparam logic [19:0] SER_WORD = {10'h009, 10'h005};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        mreset_n, load_n, pick0, pick1, timing_sel;
    logic        wclk, rclk, wen_n, ren_n, ser_en_n, ser_in;
    logic        empty_n, aempty_n, half_n, afull_n, full_n;
    logic [4:0]  flags;
    int          n_fail = 0;
    int          cmp_count = 0;

    assign flags = {full_n, afull_n, half_n, aempty_n, empty_n};

    pflag_logic i_pflag_logic (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .master_reset_n_i(mreset_n), .load_select_n_i(load_n), .default_pick_0_i(pick0),
        .default_pick_1_i(pick1), .flag_timing_sel_i(timing_sel), .wclk_i(wclk),
        .rclk_i(rclk), .wen_n_i(wen_n), .ren_n_i(ren_n), .serial_load_en_n_i(ser_en_n),
        .serial_in_i(ser_in), .empty_n_o(empty_n), .almost_empty_n_o(aempty_n),
        .half_full_n_o(half_n), .almost_full_n_o(afull_n), .full_n_o(full_n),
        .irq_o(irq));

    pflag_pin_model i_pflag_pin_model (.clk_i(clk), .wclk_o(wclk), .rclk_o(rclk),
        .wen_n_o(wen_n), .ren_n_o(ren_n), .ser_en_n_o(ser_en_n), .si_o(ser_in));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // flags {full, afull, half, aempty, empty} expected at word count c
    function automatic logic [4:0] exp_fl(int c, int n, int m);
        return {c != 1024, c < 1024 - m, c <= 512, c > n, c != 0};
    endfunction : exp_fl

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, waits for pready under a bound, checks the error response
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic e);
        int k;
        k = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_fail++;
            give_verdict();
        end
        chk({31'h0, pslverr}, {31'h0, e}, "slverr");
        @(posedge clk);
    endtask : acc

    // master reset with config pins set as it asserts and held stable through and after it
    task automatic mreset(input logic [3:0] cfg);
        {load_n, pick1, pick0, timing_sel} <= cfg;
        mreset_n <= 1'b0;
        repeat (6) @(posedge clk);
        mreset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : mreset

    // watchdog cuts a hang short
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        {clk, psel, penable, pwrite, paddr, pwdata} = '0;
        {rst, mreset_n, load_n, pick1, pick0, timing_sel} = 6'h30;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(flags), 32'(exp_fl(0, 127, 127)), "reset flags");
        foreach (ROWS[i]) begin
            mreset(ROWS[i].cfg);
            acc(1'b0, OFS_EMPTY, '0, 1'b0);
            chk(rdat, 32'(ROWS[i].dflt), "n default");
            acc(1'b0, OFS_FULL, '0, 1'b0);
            chk(rdat, 32'(ROWS[i].dflt), "m default");
            acc(1'b0, OFS_STATUS, '0, 1'b0);
            chk(32'(rdat[6:5]), {30'h0, ROWS[i].cfg[0], ROWS[i].cfg[3]}, "mode");
        end
        // pins moved after master reset must not change the latched mode
        {load_n, pick1, pick0, timing_sel} <= 4'hF;
        repeat (4) @(posedge clk);
        acc(1'b0, OFS_STATUS, '0, 1'b0);
        chk(32'(rdat[6:5]), 32'h0, "mode held");
        acc(1'b1, OFS_EMPTY, 32'h2, 1'b0);
        acc(1'b1, OFS_FULL, 32'h3, 1'b0);
        acc(1'b0, OFS_FULL, '0, 1'b0);
        chk(rdat, 32'h3, "m readback");
        for (int c = 1; c <= 1024; c++) begin
            i_pflag_pin_model.pulse(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
            chk(32'(flags), 32'(exp_fl(c, 2, 3)), "fill");
        end
        chk(32'(irq), 32'h0, "masked irq");
        acc(1'b1, OFS_IRQ_MASK, 32'h1 << IRQ_DROP, 1'b0);
        i_pflag_pin_model.pulse(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b0, OFS_STATUS, '0, 1'b0);
        chk(32'(rdat[ST_CNT_LSB+:11]), 32'd1024, "write when full");
        chk(32'(irq), 32'h1, "drop irq");
        acc(1'b1, OFS_IRQ_STAT, 32'h1F, 1'b0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "irq cleared");
        for (int c = 1023; c >= 0; c--) begin
            i_pflag_pin_model.pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
            chk(32'(flags), 32'(exp_fl(c, 2, 3)), "drain");
        end
        // serial mode with synchronous timing
        mreset(4'hF);
        acc(1'b1, OFS_EMPTY, 32'h1, 1'b1);
        load_n <= 1'b0;
        for (int b = 0; b < 20; b++) begin
            i_pflag_pin_model.pulse(1'b1, 1'b1, 1'b1, 1'b0, SER_WORD[b]);
        end
        load_n <= 1'b1;
        acc(1'b0, OFS_EMPTY, '0, 1'b0);
        chk(rdat, 32'h5, "serial n");
        acc(1'b0, OFS_FULL, '0, 1'b0);
        chk(rdat, 32'h9, "serial m");
        repeat (7) i_pflag_pin_model.pulse(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        chk(32'(aempty_n), 32'h0, "ae held on writes");
        i_pflag_pin_model.pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        chk(32'(aempty_n), 32'h1, "ae on read edge");
        acc(1'b0, 12'h020, '0, 1'b1);
        chk(rdat, 32'h0, "unmapped read");
        give_verdict();
    end
endmodule : pflag_logic_tb

// ---- verif/pflag_pin_model.sv ----
// writer and reader model driving the fifo control pins
`timescale 1ns/1ps
module pflag_pin_model (
    // clock
    input  wire logic clk_i,
    // fifo pins
    output logic      wclk_o,
    output logic      rclk_o,
    output logic      wen_n_o,
    output logic      ren_n_o,
    output logic      ser_en_n_o,
    output logic      si_o
);
    initial begin
        // link clocks idle low, active-low strobes idle high
        {wclk_o, rclk_o, wen_n_o, ren_n_o, ser_en_n_o, si_o} = 6'h0E;
    end

    // levels held 4 clk: the pins are sampled, so they may not toggle faster than 3 clk
    task automatic hold4();
        repeat (4) @(posedge clk_i);
    endtask : hold4

    // one pin clock pulse with its strobes; wr picks the write or the read clock
    task automatic pulse(input logic wr, input logic w_n, input logic r_n,
                         input logic s_n, input logic b);
        // one idle edge first, so the last release is never overwritten in its own step
        @(posedge clk_i);
        wen_n_o    <= w_n;
        ren_n_o    <= r_n;
        ser_en_n_o <= s_n;
        si_o       <= b;
        hold4();
        if (wr) begin
            wclk_o <= 1'b1;
        end else begin
            rclk_o <= 1'b1;
        end
        hold4();
        {wclk_o, rclk_o} <= 2'h0;
        hold4();
        // released data line shows the inverse so a stale bit is never taken
        {wen_n_o, ren_n_o, ser_en_n_o, si_o} <= {3'h7, ~b};
    endtask : pulse
endmodule : pflag_pin_model
